// ### ltxd_pkg.sv
package ltxd_pkg;

    // ----------------------------------------------------------------
    // Opcode fields
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_LATCH_WRITE = 6'h29;   // 1010 01
    localparam logic [5:0] OP_LATCH_READ = 6'h28;    // 1010 00
    localparam logic [7:0] OP_ZERO_TEST = 8'h33;     // 0011 0011
    localparam logic [7:0] OP_LITERAL_XOR = 8'hB4;   // 1011 0100
    localparam logic [6:0] OP_REGISTER_XOR = 7'h06;  // 0000 110
    localparam int SEL_BIT = 9;
    localparam int DEST_BIT = 8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] WORKING_REGISTER_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;

    typedef enum logic [2:0] {
        LTXD_OP_NONE,
        LTXD_OP_LWRITE,
        LTXD_OP_LREAD,
        LTXD_OP_ZTEST,
        LTXD_OP_LXOR,
        LTXD_OP_RXOR
    } ltxd_op_t;

endpackage

// ### ltxd_file_ram.sv
`timescale 1ns/100ps
module ltxd_file_ram (
    input wire logic clk_i,
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o,
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i
);
    logic [7:0] mem [0:255];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

// ### ltxd_core.sv
`timescale 1ns/100ps
module ltxd_core (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_I,
    input wire logic FILE_WE_I,
    input wire logic [7:0] FILE_WADDR_I,
    input wire logic [7:0] FILE_WDATA_I,
    output logic INSTR_READY_O,
    output logic SKIP_FLUSH_O,
    output logic [7:0] WORKING_REGISTER_O,
    output logic ZERO_FLAG_O,
    output logic [15:0] TABLE_LATCH_O,
    output logic PROG_WRITE_START_O,
    output logic FILE_WRITE_O,
    output logic [7:0] FILE_WRITE_ADDR_O,
    output logic [7:0] FILE_WRITE_DATA_O
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic ltxd_pkg::ltxd_op_t decode(input logic [15:0] ins);
        ltxd_pkg::ltxd_op_t op;
        op = ltxd_pkg::LTXD_OP_NONE;
        if (ins[15:10] == ltxd_pkg::OP_LATCH_WRITE) begin
            op = ltxd_pkg::LTXD_OP_LWRITE;
        end else if (ins[15:10] == ltxd_pkg::OP_LATCH_READ) begin
            op = ltxd_pkg::LTXD_OP_LREAD;
        end else if (ins[15:8] == ltxd_pkg::OP_ZERO_TEST) begin
            op = ltxd_pkg::LTXD_OP_ZTEST;
        end else if (ins[15:8] == ltxd_pkg::OP_LITERAL_XOR) begin
            op = ltxd_pkg::LTXD_OP_LXOR;
        end else if (ins[15:9] == ltxd_pkg::OP_REGISTER_XOR) begin
            op = ltxd_pkg::LTXD_OP_RXOR;
        end
        return op;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LTXD_ST_IDLE,
        LTXD_ST_EXEC,
        LTXD_ST_SKIP
    } ltxd_state_t;

    typedef struct packed {
        ltxd_state_t st;
        ltxd_pkg::ltxd_op_t op;
        logic sel;
        logic [7:0] lit;
        logic [7:0] working_register;
        logic zero;
        logic [7:0] lat_hi;
        logic [7:0] lat_lo;
        logic ready;
        logic skip;
        logic fwe;
        logic [7:0] faddr;
        logic [7:0] fdata;
    } ltxd_reg_t;

    ltxd_reg_t s_q;
    ltxd_reg_t s_d;
    logic [7:0] file_rdata;
    logic [7:0] ram_raddr;
    logic [7:0] res;
    logic ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;

    // Read address taken straight from the instruction so data lands in EXEC
    assign ram_raddr = INSTR_I[7:0];
    // Internal writebacks take priority over external loads
    assign ram_we = s_q.fwe | FILE_WE_I;
    assign ram_waddr = s_q.fwe ? s_q.faddr : FILE_WADDR_I;
    assign ram_wdata = s_q.fwe ? s_q.fdata : FILE_WDATA_I;

    ltxd_file_ram u_ram (
        .clk_i(CLK_I),
        .raddr_i(ram_raddr),
        .rdata_o(file_rdata),
        .we_i(ram_we),
        .waddr_i(ram_waddr),
        .wdata_i(ram_wdata)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        res = 8'h00;
        s_d = s_q;
        s_d.fwe = 1'b0;
        s_d.skip = 1'b0;
        s_d.ready = 1'b1;
        case (s_q.st)
            LTXD_ST_IDLE: begin
                if (INSTR_VALID_I) begin
                    s_d.op = decode(INSTR_I);
                    // Register xor keeps its destination in the lower bit
                    if (s_d.op == ltxd_pkg::LTXD_OP_RXOR) begin
                        s_d.sel = INSTR_I[ltxd_pkg::DEST_BIT];
                    end else begin
                        s_d.sel = INSTR_I[ltxd_pkg::SEL_BIT];
                    end
                    s_d.lit = INSTR_I[7:0];
                    s_d.faddr = INSTR_I[7:0];
                    s_d.st = LTXD_ST_EXEC;
                    s_d.ready = 1'b0;
                end
            end
            LTXD_ST_EXEC: begin
                s_d.st = LTXD_ST_IDLE;
                case (s_q.op)
                    ltxd_pkg::LTXD_OP_LWRITE: begin
                        // Only the latch moves; no instruction starts a program write (PROG_WRITE_START_O stays 0)
                        if (s_q.sel) begin
                            s_d.lat_hi = file_rdata;
                        end else begin
                            s_d.lat_lo = file_rdata;
                        end
                    end
                    ltxd_pkg::LTXD_OP_LREAD: begin
                        s_d.fwe = 1'b1;
                        s_d.fdata = s_q.sel ? s_q.lat_hi : s_q.lat_lo;
                    end
                    ltxd_pkg::LTXD_OP_ZTEST: begin
                        if (file_rdata == 8'h00) begin
                            s_d.skip = 1'b1;
                            s_d.ready = 1'b0;
                            s_d.st = LTXD_ST_SKIP;
                        end
                    end
                    ltxd_pkg::LTXD_OP_LXOR: begin
                        res = s_q.working_register ^ s_q.lit;
                        s_d.working_register = res;
                        s_d.zero = (res == 8'h00);
                    end
                    ltxd_pkg::LTXD_OP_RXOR: begin
                        res = s_q.working_register ^ file_rdata;
                        s_d.zero = (res == 8'h00);
                        if (s_q.sel) begin
                            s_d.fwe = 1'b1;
                            s_d.fdata = res;
                        end else begin
                            s_d.working_register = res;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            LTXD_ST_SKIP: begin
                // Flushed slot executes as a no-operation
                s_d.st = LTXD_ST_IDLE;
            end
            default: begin
                s_d.st = LTXD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_q <= '0;
            s_q.st <= LTXD_ST_IDLE;
            s_q.op <= ltxd_pkg::LTXD_OP_NONE;
            s_q.working_register <= ltxd_pkg::WORKING_REGISTER_RST;
            s_q.lat_hi <= ltxd_pkg::LATCH_RST;
            s_q.lat_lo <= ltxd_pkg::LATCH_RST;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb begin
        INSTR_READY_O = s_q.ready;
        SKIP_FLUSH_O = s_q.skip;
        WORKING_REGISTER_O = s_q.working_register;
        ZERO_FLAG_O = s_q.zero;
        TABLE_LATCH_O = {s_q.lat_hi, s_q.lat_lo};
        PROG_WRITE_START_O = 1'b0;
        FILE_WRITE_O = s_q.fwe;
        FILE_WRITE_ADDR_O = s_q.faddr;
        FILE_WRITE_DATA_O = s_q.fdata;
    end
endmodule

// ### ltxd_core_sva.sv
`timescale 1ns/100ps
module ltxd_core_sva (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic INSTR_VALID_I,
    input wire logic [15:0] INSTR_I,
    input wire logic INSTR_READY_O,
    input wire logic SKIP_FLUSH_O,
    input wire logic [7:0] WORKING_REGISTER_O,
    input wire logic ZERO_FLAG_O,
    input wire logic [15:0] TABLE_LATCH_O,
    input wire logic PROG_WRITE_START_O,
    input wire logic FILE_WRITE_O,
    input wire logic [7:0] FILE_WRITE_ADDR_O,
    input wire logic [7:0] FILE_WRITE_DATA_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    logic tk;
    assign tk = INSTR_VALID_I && INSTR_READY_O;
    property p_noprog; !PROG_WRITE_START_O; endproperty
    a_noprog: assert property (p_noprog) else $error("program write started");
    property p_busy; tk |=> !INSTR_READY_O; endproperty
    a_busy: assert property (p_busy) else $error("ready after take");
    property p_skip; SKIP_FLUSH_O |-> !INSTR_READY_O ##1 (INSTR_READY_O && !SKIP_FLUSH_O); endproperty
    a_skip: assert property (p_skip) else $error("skip cycle wrong");
    property p_skipsrc; SKIP_FLUSH_O |-> $past(INSTR_I[15:8], 2) == 8'h33; endproperty
    a_skipsrc: assert property (p_skipsrc) else $error("skip without zero test");
    property p_lwrite; tk && INSTR_I[15:10] == 6'h29 |-> ##2 !FILE_WRITE_O && ($past(INSTR_I[9], 2) ?
        TABLE_LATCH_O[7:0] == $past(TABLE_LATCH_O[7:0], 2) : TABLE_LATCH_O[15:8] == $past(TABLE_LATCH_O[15:8], 2));
    endproperty
    a_lwrite: assert property (p_lwrite) else $error("other latch byte changed");
    property p_lxor; tk && INSTR_I[15:8] == 8'hB4 |-> ##2 ZERO_FLAG_O == (WORKING_REGISTER_O == 8'h00) &&
        WORKING_REGISTER_O == ($past(WORKING_REGISTER_O, 2) ^ $past(INSTR_I[7:0], 2)); endproperty
    a_lxor: assert property (p_lxor) else $error("literal xor wrong");
    property p_rxor; tk && INSTR_I[15:8] == 8'h0D |-> ##2 FILE_WRITE_O && ZERO_FLAG_O == (FILE_WRITE_DATA_O == 8'h00)
        && FILE_WRITE_ADDR_O == $past(INSTR_I[7:0], 2) && WORKING_REGISTER_O == $past(WORKING_REGISTER_O, 2);
    endproperty
    a_rxor: assert property (p_rxor) else $error("register xor to file wrong");
    property p_rxorw; tk && INSTR_I[15:8] == 8'h0C |-> ##2 !FILE_WRITE_O && ZERO_FLAG_O == (WORKING_REGISTER_O == 8'h00);
    endproperty
    a_rxorw: assert property (p_rxorw) else $error("register xor to working register wrong");
    property p_lread; tk && INSTR_I[15:10] == 6'h28 |-> ##2 FILE_WRITE_O && TABLE_LATCH_O == $past(TABLE_LATCH_O, 2)
        && FILE_WRITE_DATA_O == ($past(INSTR_I[9], 2) ? $past(TABLE_LATCH_O[15:8], 2) : $past(TABLE_LATCH_O[7:0], 2));
    endproperty
    a_lread: assert property (p_lread) else $error("latch read wrong");
endmodule
bind ltxd_core ltxd_core_sva u_sva (.CLK_I(CLK_I), .NRST_I(NRST_I), .INSTR_VALID_I(INSTR_VALID_I),
    .INSTR_I(INSTR_I), .INSTR_READY_O(INSTR_READY_O), .SKIP_FLUSH_O(SKIP_FLUSH_O),
    .WORKING_REGISTER_O(WORKING_REGISTER_O), .ZERO_FLAG_O(ZERO_FLAG_O), .TABLE_LATCH_O(TABLE_LATCH_O),
    .PROG_WRITE_START_O(PROG_WRITE_START_O), .FILE_WRITE_O(FILE_WRITE_O),
    .FILE_WRITE_ADDR_O(FILE_WRITE_ADDR_O), .FILE_WRITE_DATA_O(FILE_WRITE_DATA_O));

// ### latch_write_test_skip_xor_exec_bench.sv
`timescale 1ns/100ps
module latch_write_test_skip_xor_exec_bench;
    logic clk = 1'b0, nrst = 1'b0, vld = 1'b0, we = 1'b0, rdy, skp, zf, pws, fw;
    logic [15:0] ins = 16'h0000, lat, m_l;
    logic [7:0] wa = 8'h00, wd = 8'h00, wr, fwa, fwd, m_w;
    logic [7:0] fm [256];
    logic m_z;
    int fail_count = 0, tests_run = 0;
    logic [15:0] ops [7] = '{16'hA400, 16'hA000, 16'h3300, 16'hB400, 16'h0C00, 16'h0D00, 16'hFF00};
    always #10 clk = ~clk;
    ltxd_core uut (.CLK_I(clk), .NRST_I(nrst), .INSTR_VALID_I(vld), .INSTR_I(ins), .FILE_WE_I(we),
        .FILE_WADDR_I(wa), .FILE_WDATA_I(wd), .INSTR_READY_O(rdy), .SKIP_FLUSH_O(skp), .WORKING_REGISTER_O(wr),
        .ZERO_FLAG_O(zf), .TABLE_LATCH_O(lat), .PROG_WRITE_START_O(pws), .FILE_WRITE_O(fw),
        .FILE_WRITE_ADDR_O(fwa), .FILE_WRITE_DATA_O(fwd));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, s);
            fail_count++;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic load(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        we = 1'b1; wa = a; wd = d; fm[a] = d;
        @(posedge clk) #1;
        we = 1'b0;
    endtask
    // Expected latch, working register, zero flag and file write
    task automatic run(input logic [15:0] i);
        int n;
        logic sk, ew, zt;
        logic [7:0] f, r;
        n = 0; sk = 0; ew = 0; f = fm[i[7:0]]; zt = i[15:8] == 8'h33 && f == 8'h00;
        @(posedge clk) #1;
        vld = 1'b1; ins = i;
        @(posedge clk) #1;
        vld = 1'b0;
        chk("busy", 0, rdy);
        do begin @(posedge clk) #1; sk |= skp; n++; end while (!rdy && n < 4);
        r = m_w ^ (i[15:8] == 8'hB4 ? i[7:0] : f);
        if (i[15:10] == 6'h29) m_l = i[9] ? {f, m_l[7:0]} : {m_l[15:8], f};
        if (i[15:10] == 6'h28) begin ew = 1; r = i[9] ? m_l[15:8] : m_l[7:0]; end
        if (i[15:8] == 8'hB4 || i[15:9] == 7'h06) begin m_z = r == 8'h00; ew = i[15:8] == 8'h0D; end
        if ((i[15:8] == 8'hB4 || i[15:8] == 8'h0C)) m_w = r;
        if (ew) fm[i[7:0]] = r;
        chk("skip", zt, sk);
        chk("cycles", zt ? 2 : 1, n);
        chk("fwrite", ew, fw);
        if (ew) chk("fdata", {r, i[7:0]}, {fwd, fwa});
        chk("working_register", m_w, wr);
        chk("zero", m_z, zf);
        chk("latch", m_l, lat);
        chk("prog", 0, pws);
    endtask
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    initial begin
        void'($urandom(41407));
        m_w = 8'h00; m_z = 1'b0; m_l = 16'h0000;
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        for (int a = 0; a < 16; a++) load(a[7:0], a < 3 ? 8'h00 : 8'($urandom | 1));
        foreach (ops[k]) run(ops[k] | 16'h0205);
        foreach (ops[k]) run(ops[k] | 16'h0100);
        run({8'hB4, m_w});
        run(16'h3301);
        // ----------------------------------------------------------------
        // Reset in mid-run
        // ----------------------------------------------------------------
        @(posedge clk) #1 nrst = 1'b0;
        m_w = 8'h00; m_z = 1'b0; m_l = 16'h0000;
        @(posedge clk) #1;
        chk("rstrdy", {1'b1, 8'h00, 16'h0000}, {rdy, wr, lat});
        nrst = 1'b1;
        repeat (300) begin
            int k;
            k = $urandom % 7;
            if ($urandom % 4 == 0) load(8'($urandom % 16), $urandom % 2 ? 8'h00 : 8'($urandom));
            run(ops[k] | (k == 3 ? 16'($urandom % 256) : 16'($urandom & 32'h030F)));
        end
        complete_run();
    end
endmodule
